// *** sram_cycle_params.svh ***
// Constants for the burst SRAM cycle-control block
`ifndef SRAM_CYCLE_PARAMS_SVH
`define SRAM_CYCLE_PARAMS_SVH
`define SRAM_ADDR_W 17
`define SRAM_DATA_W 32
`define SRAM_LANES 4
`define SRAM_LO_W 2
`define SRAM_SYNC_W 3
`define SRAM_LANE_NONE 4'h0
`define SRAM_LANE_ALL 4'hF
`define SRAM_STEP_ZERO 2'h0
`define SRAM_STEP_ONE 2'h1
`endif

// *** sram_cycle_pkg.sv ***
// Types for the burst SRAM cycle-control block
`include "sram_cycle_params.svh"
package sram_cycle_pkg;
  typedef enum logic [4:0] {
    OP_DESELECT = 5'h01,
    OP_BEGIN_READ = 5'h02,
    OP_BEGIN_EXT = 5'h04,
    OP_CONTINUE = 5'h08,
    OP_SUSPEND = 5'h10
  } op_t;

  typedef struct packed {
    logic select_primary_n;
    logic select_expand_hi;
    logic select_expand_lo_n;
    logic strobe_processor_n;
    logic strobe_controller_n;
    logic burst_advance_n;
    logic write_all_lanes_n;
    logic byte_write_gate_n;
    logic lane_d_write_n;
    logic lane_c_write_n;
    logic lane_b_write_n;
    logic lane_a_write_n;
    logic [`SRAM_ADDR_W-1:0] addr;
  } bus_in_t;

  typedef struct packed {
    logic [`SRAM_ADDR_W-1:0] addr;
    logic [`SRAM_LANES-1:0] lane_we;
    logic [`SRAM_DATA_W-1:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic [`SRAM_SYNC_W-1:0] sleep_sync;
    logic [`SRAM_SYNC_W-1:0] mode_sync;
    logic asleep;
    logic interleave;
    logic active;
    logic [`SRAM_ADDR_W-1:0] base_addr;
    logic [`SRAM_LO_W-1:0] step;
    logic rd;
    logic out_valid;
    logic [`SRAM_DATA_W-1:0] out_data;
    core_req_t core;
  } state_t;
endpackage

// *** sram_cycle_ctrl.sv ***
// Cycle control for a pipelined single-cycle-deselect burst SRAM
`timescale 1ns/100ps
`default_nettype none
`include "sram_cycle_params.svh"

// Operation
// - Deselect on listed select/strobe combinations; no access, pins undriven.
// - Processor strobe with all selects starts a read burst, ignoring writes.
// - Controller strobe alone with selects starts burst; write if qualified low.
// - Writes only after processor-strobe cycle or with controller-strobe start.
// - Strobes idle and advance low steps burst to next address.
// - Strobes idle and advance high repeats current address.
// - Every write cycle captures data pins at the clock rise.
// - Qualified write low on global write, or gate with any lane enable.
// - Global write writes all lanes; else gated lanes selected individually.
// - Data pin drive follows current cycle's operation and output enable.
// - Output enable acts combinationally, never sampled.
// - Output enable is masked during write cycles; pins stay undriven.
// - Reads drive all bits when enable low; undriven if high or deselected.
// - Sleep input enters low power, abandons accesses, keeps data, releases pins.
// - Read data appears on pins after the clock rise following address.
// - After deselect, outputs drive one more cycle, release after next rise.
module sram_cycle_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Synchronous bus from the master
  input wire sram_cycle_pkg::bus_in_t bus,
  // Asynchronous controls
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_mode,
  // Shared data pins
  input wire logic [`SRAM_DATA_W-1:0] dq_in,
  output logic [`SRAM_DATA_W-1:0] dq_out,
  output logic dq_oe,
  // Memory core
  output var sram_cycle_pkg::core_req_t core_req,
  input wire logic [`SRAM_DATA_W-1:0] core_rdata,
  // Status
  output logic sleep_active
);
  import sram_cycle_pkg::*;

  state_t st_ff;
  state_t nxt_st;
  op_t op;
  logic qual_write_n;
  logic [`SRAM_LANES-1:0] lanes;

  // Low address bits of a burst for the given step
  function automatic logic [`SRAM_LO_W-1:0] burst_lo(
    input logic [`SRAM_LO_W-1:0] base,
    input logic [`SRAM_LO_W-1:0] step,
    input logic interleave
  );
    if (interleave) begin
      burst_lo = base ^ step;
    end else begin
      burst_lo = base + step;
    end
  endfunction

  // Picks this cycle's operation from selects and strobes
  function automatic op_t decode_op(
    input bus_in_t b,
    input logic active
  );
    logic sel_all;
    sel_all = !b.select_primary_n && b.select_expand_hi
      && !b.select_expand_lo_n;
    if (!b.strobe_processor_n && !b.select_primary_n) begin
      decode_op = sel_all ? OP_BEGIN_READ : OP_DESELECT;
    end else if (!b.strobe_controller_n) begin
      decode_op = sel_all ? OP_BEGIN_EXT : OP_DESELECT;
    end else if (!active) begin
      decode_op = OP_DESELECT;
    end else if (!b.burst_advance_n) begin
      decode_op = OP_CONTINUE;
    end else begin
      decode_op = OP_SUSPEND;
    end
  endfunction

  // Qualified write and byte lanes, lane A in bit 0
  assign qual_write_n = !(!bus.write_all_lanes_n || (!bus.byte_write_gate_n
    && !(&{bus.lane_d_write_n, bus.lane_c_write_n, bus.lane_b_write_n,
    bus.lane_a_write_n})));
  always_comb begin
    if (!bus.write_all_lanes_n) begin
      lanes = `SRAM_LANE_ALL;
    end else if (!bus.byte_write_gate_n) begin
      lanes = ~{bus.lane_d_write_n, bus.lane_c_write_n,
        bus.lane_b_write_n, bus.lane_a_write_n};
    end else begin
      lanes = `SRAM_LANE_NONE;
    end
  end

  assign op = decode_op(bus, st_ff.active);

  always_comb begin
    nxt_st = st_ff;
    // Three-stage synchronisers; level taken when last two agree
    nxt_st.sleep_sync = {st_ff.sleep_sync[`SRAM_SYNC_W-2:0], sleep_request};
    nxt_st.mode_sync = {st_ff.mode_sync[`SRAM_SYNC_W-2:0], burst_mode};
    if (st_ff.sleep_sync[`SRAM_SYNC_W-1] == st_ff.sleep_sync[`SRAM_SYNC_W-2])
      begin
      nxt_st.asleep = st_ff.sleep_sync[`SRAM_SYNC_W-1];
    end
    if (st_ff.mode_sync[`SRAM_SYNC_W-1] == st_ff.mode_sync[`SRAM_SYNC_W-2])
      begin
      nxt_st.interleave = st_ff.mode_sync[`SRAM_SYNC_W-1];
    end
    // Output register stage
    nxt_st.out_valid = st_ff.rd;
    if (st_ff.rd) begin
      nxt_st.out_data = core_rdata;
    end
    nxt_st.rd = 1'b0;
    nxt_st.core.lane_we = `SRAM_LANE_NONE;
    case (op)
      OP_DESELECT: begin
        nxt_st.active = 1'b0;
      end
      OP_BEGIN_READ: begin
        nxt_st.active = 1'b1;
        nxt_st.base_addr = bus.addr;
        nxt_st.step = `SRAM_STEP_ZERO;
        nxt_st.core.addr = bus.addr;
        nxt_st.rd = 1'b1;
      end
      OP_BEGIN_EXT: begin
        nxt_st.active = 1'b1;
        nxt_st.base_addr = bus.addr;
        nxt_st.step = `SRAM_STEP_ZERO;
        nxt_st.core.addr = bus.addr;
        nxt_st.rd = qual_write_n;
      end
      OP_CONTINUE: begin
        nxt_st.step = st_ff.step + `SRAM_STEP_ONE;
        nxt_st.core.addr = {st_ff.base_addr[`SRAM_ADDR_W-1:`SRAM_LO_W],
          burst_lo(st_ff.base_addr[`SRAM_LO_W-1:0], nxt_st.step,
          st_ff.interleave)};
        nxt_st.rd = qual_write_n;
      end
      OP_SUSPEND: begin
        nxt_st.core.addr = {st_ff.base_addr[`SRAM_ADDR_W-1:`SRAM_LO_W],
          burst_lo(st_ff.base_addr[`SRAM_LO_W-1:0], st_ff.step,
          st_ff.interleave)};
        nxt_st.rd = qual_write_n;
      end
      default: begin
        nxt_st.active = 1'b0;
      end
    endcase
    // Write cycles capture the data pins at this rise
    if (op != OP_DESELECT && op != OP_BEGIN_READ && !qual_write_n) begin
      nxt_st.core.lane_we = lanes;
      nxt_st.core.wdata = dq_in;
    end
    // Sleep abandons pending accesses from the entry edge on
    if (nxt_st.asleep) begin
      nxt_st.active = 1'b0;
      nxt_st.rd = 1'b0;
      nxt_st.out_valid = 1'b0;
      nxt_st.core.lane_we = `SRAM_LANE_NONE;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dq_out = st_ff.out_data;
  assign dq_oe = st_ff.out_valid && !output_enable_n
    && (st_ff.core.lane_we == `SRAM_LANE_NONE) && !st_ff.asleep;
  assign core_req = st_ff.core;
  assign sleep_active = st_ff.asleep;
endmodule
`default_nettype wire

// *** sram_cycle_ctrl_monitor.sv ***
// Assertion checker for the SRAM cycle-control block
`timescale 1ns/100ps
`default_nettype none
`include "sram_cycle_params.svh"
module sram_cycle_ctrl_monitor (
  // Clock, reset and controls
  input wire logic ref_clk, arst_n, output_enable_n, sleep_request,
  input wire logic burst_mode,
  // Bus, data pins and core
  input wire sram_cycle_pkg::bus_in_t bus,
  input wire logic [`SRAM_DATA_W-1:0] dq_in, dq_out, core_rdata,
  input wire logic dq_oe, sleep_active,
  input wire sram_cycle_pkg::core_req_t core_req
);
  import sram_cycle_pkg::*;
  logic sel, go;
  logic [3:0] lanes_n;
  assign sel = !bus.select_primary_n && bus.select_expand_hi
    && !bus.select_expand_lo_n;
  assign go = sel && !sleep_active && !sleep_request;
  assign lanes_n = {bus.lane_d_write_n, bus.lane_c_write_n,
    bus.lane_b_write_n, bus.lane_a_write_n};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  sequence s_rd; go && !bus.strobe_processor_n; endsequence
  sequence s_ctl; go && bus.strobe_processor_n && !bus.strobe_controller_n;
  endsequence
  a_oe_off_high: assert property (output_enable_n |-> !dq_oe)
    else $error("data pins driven with enable off");
  a_write_masks_oe: assert property (|core_req.lane_we |-> !dq_oe)
    else $error("data pins driven in a write cycle");
  a_sleep_quiet: assert property (sleep_active |->
    !dq_oe && core_req.lane_we == 4'h0) else $error("activity in sleep");
  a_proc_start_read: assert property (s_rd |=>
    core_req.lane_we == 4'h0 && core_req.addr == $past(bus.addr))
    else $error("processor start not a read at the given address");
  a_ctrl_full_write: assert property (s_ctl ##0 !bus.write_all_lanes_n |=>
    core_req.lane_we == 4'hF && core_req.wdata == $past(dq_in))
    else $error("controller start global write wrong");
  a_lane_select: assert property (s_ctl ##0 bus.write_all_lanes_n
    ##0 !bus.byte_write_gate_n |=> core_req.lane_we == ~$past(lanes_n))
    else $error("byte lane write enables wrong");
  a_deselect_idle: assert property (!bus.strobe_controller_n
    && bus.select_primary_n |=> core_req.lane_we == 4'h0)
    else $error("write during deselect");
  a_suspend_holds: assert property (!sleep_active && !sleep_request
    && bus.strobe_processor_n && bus.strobe_controller_n
    && bus.burst_advance_n |=> $stable(core_req.addr))
    else $error("suspended burst moved the address");
  a_read_to_pins: assert property (s_rd ##1 1 |=> output_enable_n
    || |core_req.lane_we || sleep_active || dq_oe)
    else $error("read data not driven on time");
endmodule
bind sram_cycle_ctrl sram_cycle_ctrl_monitor sram_cycle_ctrl_monitor_inst (
  .ref_clk, .arst_n, .output_enable_n, .sleep_request, .burst_mode, .bus,
  .dq_in, .dq_out, .core_rdata, .dq_oe, .sleep_active, .core_req);
`default_nettype wire

// *** sram_core_model.sv ***
// Behavioural memory core behind the cycle-control block
`timescale 1ns/100ps
`default_nettype none
module sram_core_model (
  input wire logic ref_clk,
  input wire sram_cycle_pkg::core_req_t core_req,
  output logic [31:0] core_rdata
);
  import sram_cycle_pkg::*;
  logic [31:0] mem [0:63];
  assign core_rdata = mem[core_req.addr[5:0]];
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (core_req.lane_we[i]) begin
        mem[core_req.addr[5:0]][8*i+:8] <= core_req.wdata[8*i+:8];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_sync_burst_sram_cycle_control.sv ***
// Self-checking bench for the SRAM cycle-control block
`timescale 1ns/100ps
`default_nettype none
module tb_sync_burst_sram_cycle_control;
  import sram_cycle_pkg::*;
  logic ref_clk = 1'b0, arst_n = 1'b0, output_enable_n = 1'b0;
  logic sleep_request = 1'b0, burst_mode = 1'b0, dq_oe, sleep_active;
  logic [31:0] dq_in = 32'h0, dq_out, core_rdata;
  bus_in_t bus = '0;
  core_req_t core_req;
  int error_cnt = 0, n_checks = 0;
  sram_cycle_ctrl sram_cycle_ctrl_inst (.ref_clk, .arst_n, .bus,
    .output_enable_n, .sleep_request, .burst_mode, .dq_in, .dq_out, .dq_oe,
    .core_req, .core_rdata, .sleep_active);
  sram_core_model sram_core_model_inst (.ref_clk, .core_req, .core_rdata);
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle: drive at the falling edge, settle after the rise
  task automatic cyc(input logic p_n, c_n, adv_n, gw_n, gate_n,
      input logic [3:0] bw_n, input logic [16:0] a,
      input logic [31:0] d = 32'h0, input logic [2:0] sel = 3'b010);
    @(negedge ref_clk);
    bus = {sel, p_n, c_n, adv_n, gw_n, gate_n, bw_n, a};
    dq_in = d;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic desel;
    cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 4'hF, 17'h0, 32'h0, 3'b110);
  endtask
  task automatic t_write;
    @(negedge ref_clk);
    output_enable_n = 1'b1;
    cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 17'h10, 32'h11223344);
    chk(core_req.lane_we, 4'hF);
    chk(core_req.wdata, 32'h11223344);
    cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hD, 17'h10, 32'hAABBCCDD);
    chk(core_req.lane_we, 4'h2);
    chk(dq_oe, 1'b0);
    cyc(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 4'hF, 17'h10);
    chk(core_req.lane_we, 4'h0);
    @(negedge ref_clk);
    output_enable_n = 1'b0;
    desel;
    chk(dq_out, 32'h1122CC44);
    chk(dq_oe, 1'b1);
    @(negedge ref_clk);
    output_enable_n = 1'b1;
    #1 chk(dq_oe, 1'b0);
    output_enable_n = 1'b0;
    desel;
    chk(dq_oe, 1'b0);
    $display("write test done");
  endtask
  task automatic t_burst(input logic [16:0] e1, e2);
    cyc(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'hF, 17'h10013);
    chk(core_req.addr, 17'h10013);
    chk(core_req.lane_we, 4'h0);
    cyc(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'hF, 17'h0);
    chk(core_req.addr, e1);
    chk(dq_oe, 1'b1);
    cyc(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'hF, 17'h0);
    chk(core_req.addr, e1);
    @(negedge ref_clk);
    output_enable_n = 1'b1;
    cyc(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 4'hF, 17'h0, 32'h5A5A5A5A);
    chk(core_req.addr, e2);
    chk(core_req.lane_we, 4'hF);
    desel;
    @(negedge ref_clk);
    output_enable_n = 1'b0;
    $display("burst test done");
  endtask
  task automatic t_sleep;
    @(negedge ref_clk);
    sleep_request = 1'b1;
    repeat (5) @(posedge ref_clk);
    cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 4'hF, 17'h20);
    chk(sleep_active, 1'b1);
    chk(core_req.lane_we, 4'h0);
    desel;
    @(negedge ref_clk);
    sleep_request = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 chk(sleep_active, 1'b0);
    $display("sleep test done");
  endtask
  task automatic report_and_stop;
    $display("Checks made %0d, mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    error_cnt++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    arst_n = 1'b1;
    t_write;
    t_burst(17'h10010, 17'h10011);
    @(negedge ref_clk);
    burst_mode = 1'b1;
    repeat (4) @(posedge ref_clk);
    t_burst(17'h10012, 17'h10011);
    t_sleep;
    report_and_stop;
  end
endmodule
`default_nettype wire
